//--- src/seq_pkg.sv
package seq_pkg;
    localparam int LEVELS = 8;
    localparam int QUALS = 6;
    localparam int LVL_W = 3;
    localparam int ACT_W = 10;
    // configuration cell codes
    localparam logic [1:0] CELL_UNUSED = 2'h0;
    localparam logic [1:0] CELL_ADVANCE = 2'h1;
    localparam logic [1:0] CELL_RESET = 2'h2;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFF_GATE = 8'h10;
    localparam logic [7:0] OFF_ACTION = 8'h14;
    localparam logic [7:0] OFF_DEPTH = 8'h18;
    localparam logic [7:0] OFF_CELL0 = 8'h20;
    // field positions
    localparam int CTRL_LOAD_BIT = 0;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_RESTART_BIT = 1;
    localparam int IRQ_W = 2;
    // reset values
    localparam logic [LEVELS-1:0] GATE_RESET = 8'hFF;
    localparam logic [ACT_W-1:0] ACTION_RESET = 10'h000;
    localparam logic [LVL_W-1:0] DEPTH_RESET = 3'h0;
    localparam logic [IRQ_W-1:0] MASK_RESET = 2'h0;
    // action select bits
    localparam int ACT_C1_DEC = 0;
    localparam int ACT_C1_START = 1;
    localparam int ACT_C1_STOP = 2;
    localparam int ACT_C1_RELOAD = 3;
    localparam int ACT_C2_DEC = 4;
    localparam int ACT_C2_START = 5;
    localparam int ACT_C2_STOP = 6;
    localparam int ACT_C2_RELOAD = 7;
    localparam int ACT_TRACE_DIS = 8;
    localparam int ACT_BREAK = 9;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT} seq_state_t;
endpackage : seq_pkg

//--- src/seq_cell_mem.sv
`timescale 1ns/1ps
// level-by-qualifier cell store, synchronous read port for the bus
module seq_cell_mem import seq_pkg::*; (
    // clock
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // write port
    input wire logic wr_en,
    input wire logic [LVL_W-1:0] wr_level,
    input wire logic [2*QUALS-1:0] wr_cells,
    // read port
    input wire logic [LVL_W-1:0] rd_level,
    output logic [2*QUALS-1:0] rd_cells_q,
    // full view for the matcher
    output logic [LEVELS*2*QUALS-1:0] all_cells
);
    logic [2*QUALS-1:0] mem_q [LEVELS];

    genvar g;
    generate
        for (g = 0; g < LEVELS; g++) begin : g_row
            always_ff @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    mem_q[g] <= '0;
                end else if (ce && wr_en && wr_level == g[LVL_W-1:0]) begin
                    mem_q[g] <= wr_cells;
                end
            end
            assign all_cells[g*2*QUALS +: 2*QUALS] = mem_q[g];
        end
    endgenerate

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rd_cells_q <= '0;
        end else if (ce) begin
            rd_cells_q <= mem_q[rd_level];
        end
    end
endmodule : seq_cell_mem

//--- src/event_sequencer.sv
// The register offsets and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
// Notes on behaviour
// - one current level of eight
// - advance is OR of enabled qualifiers
// - qualifiers: four matches, two counter zeros
// - wait level one, then step upward
// - last level matched: complete, back to one
// - qualifiers not enabled are ignored
// - one qualifier may serve several levels
// - any enabled qualifier advances the level
// - completion strobe and action selection output apart, ANDed outside
// - reset qualifier returns to level one
// - reset cells act only at own level
// - advance beats reset in same cycle
// - trace start honoured only when gated
// - trace gate defaults on for all levels
module event_sequencer import seq_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // qualifiers, same clock domain
    input wire logic event_a_match,
    input wire logic event_b_match,
    input wire logic event_c_match,
    input wire logic event_d_match,
    input wire logic counter_one_zero,
    input wire logic counter_two_zero,
    input wire logic trace_start_req,
    // outputs
    output logic [LVL_W-1:0] level_q,
    output logic seq_done_q,
    output logic trace_start_ok,
    output logic [ACT_W-1:0] action_q,
    output logic trigger_q,
    output logic irq,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    logic [QUALS-1:0] quals;
    logic [LEVELS*2*QUALS-1:0] all_cells;
    logic [2*QUALS-1:0] rd_cells_q;
    logic [LEVELS-1:0] gate_q;
    logic [LVL_W-1:0] depth_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q;
    logic load_pulse;
    logic advance, restart, last_level;
    seq_state_t state_q;

    assign quals = {counter_two_zero, counter_one_zero,
                    event_d_match, event_c_match, event_b_match, event_a_match};

    // cell decode shared by both match kinds
    function automatic logic [QUALS-1:0] cells_of(input logic [2*QUALS-1:0] row, input logic [1:0] code);
        logic [QUALS-1:0] r;
        r = '0;
        for (int i = 0; i < QUALS; i++) begin
            r[i] = (row[2*i +: 2] == code);
        end
        return r;
    endfunction : cells_of

    // cell rows sit in one window; both bus sides decode it the same way
    function automatic logic in_cell_window(input logic [7:0] addr);
        return addr >= OFF_CELL0 && addr < OFF_CELL0 + 8'(4 * LEVELS);
    endfunction : in_cell_window

    logic [2*QUALS-1:0] cur_row;
    assign cur_row = all_cells[level_q*2*QUALS +: 2*QUALS];
    // only the current level's cells count, so stray qualifiers do nothing
    assign advance = |(quals & cells_of(cur_row, CELL_ADVANCE));
    assign restart = |(quals & cells_of(cur_row, CELL_RESET));
    assign last_level = (level_q == depth_q);

    // axi write side
    logic aw_hold_q, w_hold_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_go;
    // read level is held so a cell row cannot change under a standing rvalid
    logic [LVL_W-1:0] rd_lvl_q;
    logic wr_hit_cell, wr_ok;
    assign s_awready = !aw_hold_q && !s_bvalid;
    assign s_wready = !w_hold_q && !s_bvalid;
    assign wr_go = aw_hold_q && w_hold_q && !s_bvalid;
    assign wr_hit_cell = in_cell_window(aw_addr_q);
    assign wr_ok = wr_hit_cell || aw_addr_q == OFF_CTRL || aw_addr_q == OFF_STATUS || aw_addr_q == OFF_IRQ_STAT
                   || aw_addr_q == OFF_IRQ_MASK || aw_addr_q == OFF_GATE || aw_addr_q == OFF_ACTION
                   || aw_addr_q == OFF_DEPTH;
    assign load_pulse = ce && wr_go && aw_addr_q == OFF_CTRL && w_strb_q[0] && w_data_q[CTRL_LOAD_BIT];

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= AXI_OKAY;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= {s_awaddr[7:2], 2'b00};
            end
            if (s_wvalid && s_wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= s_wdata;
                w_strb_q <= s_wstrb;
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_ok ? AXI_OKAY : AXI_SLVERR;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gate_q <= GATE_RESET;
            action_q <= ACTION_RESET;
            depth_q <= DEPTH_RESET;
            irq_mask_q <= MASK_RESET;
        end else if (ce && wr_go && w_strb_q[0]) begin
            case (aw_addr_q)
                OFF_GATE: gate_q <= w_data_q[LEVELS-1:0];
                OFF_DEPTH: depth_q <= w_data_q[LVL_W-1:0];
                OFF_IRQ_MASK: irq_mask_q <= w_data_q[IRQ_W-1:0];
                OFF_ACTION: action_q <= {w_strb_q[1] ? w_data_q[ACT_W-1:8] : action_q[ACT_W-1:8],
                                         w_data_q[7:0]};
                default: ;
            endcase
        end
    end

    seq_cell_mem u_cells (
        .clk(clk),
        .arst_n(arst_n),
        .ce(ce),
        .wr_en(wr_go && wr_hit_cell && w_strb_q[0] && w_strb_q[1]),
        .wr_level(aw_addr_q[LVL_W+1:2]),
        .wr_cells(w_data_q[2*QUALS-1:0]),
        .rd_level(s_rvalid ? rd_lvl_q : s_araddr[LVL_W+1:2]),
        .rd_cells_q(rd_cells_q),
        .all_cells(all_cells)
    );

    // axi read side: one cycle to rvalid, cell data from the memory register
    logic rd_cell_q;
    logic [31:0] rd_reg_q;
    assign s_arready = !s_rvalid;
    assign s_rdata = rd_cell_q ? {20'h00000, rd_cells_q} : rd_reg_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_rvalid <= 1'b0;
            s_rresp <= AXI_OKAY;
            rd_cell_q <= 1'b0;
            rd_reg_q <= 32'h0000_0000;
            rd_lvl_q <= '0;
        end else if (ce) begin
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= AXI_OKAY;
                rd_cell_q <= 1'b0;
                rd_reg_q <= 32'h0000_0000;
                if (in_cell_window(s_araddr)) begin
                    rd_cell_q <= 1'b1;
                    rd_lvl_q <= s_araddr[LVL_W+1:2];
                end else begin
                    case ({s_araddr[7:2], 2'b00})
                        OFF_CTRL: ;
                        OFF_STATUS: rd_reg_q <= {27'h0, seq_done_q, 1'b0, level_q};
                        OFF_IRQ_STAT: rd_reg_q <= {30'h0, irq_stat_q};
                        OFF_IRQ_MASK: rd_reg_q <= {30'h0, irq_mask_q};
                        OFF_GATE: rd_reg_q <= {24'h0, gate_q};
                        OFF_ACTION: rd_reg_q <= {22'h0, action_q};
                        OFF_DEPTH: rd_reg_q <= {29'h0, depth_q};
                        default: s_rresp <= AXI_SLVERR;
                    endcase
                end
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

    // sequencer level machine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SEQ_IDLE;
            level_q <= '0;
            seq_done_q <= 1'b0;
        end else if (ce) begin
            seq_done_q <= 1'b0;
            if (load_pulse) begin
                state_q <= SEQ_WAIT;
                level_q <= '0;
            end else begin
                case (state_q)
                    SEQ_IDLE: state_q <= SEQ_WAIT;
                    SEQ_WAIT: begin
                        // advance tested first so it wins over restart
                        if (advance) begin
                            if (last_level) begin
                                level_q <= '0;
                                seq_done_q <= 1'b1;
                            end else begin
                                level_q <= level_q + 3'h1;
                            end
                        end else if (restart) begin
                            level_q <= '0;
                        end
                    end
                    default: state_q <= SEQ_IDLE;
                endcase
            end
        end
    end

    assign trace_start_ok = trace_start_req && gate_q[level_q];

    // action_q selects, seq_done_q strobes; outside logic ANDs the two
    // trigger always mirrors completion, whatever the selection holds
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trigger_q <= 1'b0;
        end else if (ce) begin
            trigger_q <= advance && last_level && state_q == SEQ_WAIT && !load_pulse;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= '0;
        end else if (ce) begin
            // set beats a same-cycle write-one clear
            irq_stat_q <= (irq_stat_q & ~((wr_go && aw_addr_q == OFF_IRQ_STAT && w_strb_q[0])
                                          ? w_data_q[IRQ_W-1:0] : 2'h0))
                          | {restart && !advance && state_q == SEQ_WAIT, seq_done_q};
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    a_done_resets_level: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(seq_done_q) |-> level_q == 3'h0) else $error("level not back to one after done");
    a_advance_steps: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q == SEQ_WAIT && advance && !last_level && !load_pulse |=> level_q == $past(level_q) + 3'h1)
        else $error("level did not step");
    a_advance_beats_reset: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q == SEQ_WAIT && advance && restart && !last_level && !load_pulse |=> level_q != 3'h0)
        else $error("reset won over advance");
    a_reset_to_one: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q == SEQ_WAIT && restart && !advance |=> level_q == 3'h0) else $error("reset ignored");
    a_idle_holds: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q == SEQ_WAIT && !advance && !restart && !load_pulse |=> $stable(level_q))
        else $error("level moved with no qualifier");
    a_done_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
        seq_done_q && ce |=> !seq_done_q) else $error("done wider than one cycle");
    a_trace_gate: assert property (@(posedge clk) disable iff (!arst_n)
        trace_start_ok |-> gate_q[level_q]) else $error("trace start outside gated level");
    a_load_clears: assert property (@(posedge clk) disable iff (!arst_n)
        load_pulse |=> level_q == 3'h0 && !seq_done_q) else $error("load did not restart");
    c_complete: cover property (@(posedge clk) disable iff (!arst_n) seq_done_q);
    c_restart: cover property (@(posedge clk) disable iff (!arst_n) state_q == SEQ_WAIT && restart && level_q != 3'h0);
    c_clash: cover property (@(posedge clk) disable iff (!arst_n) state_q == SEQ_WAIT && restart && advance);
    c_full_depth: cover property (@(posedge clk) disable iff (!arst_n) level_q == 3'h7);
    c_trace_open: cover property (@(posedge clk) disable iff (!arst_n) trace_start_ok);

    // trigger and completion come from one condition, so they always coincide
    a_trigger_with_done: assert property (@(posedge clk) disable iff (!arst_n)
        trigger_q == seq_done_q) else $error("trigger and completion differ");
    a_done_sets_irq: assert property (@(posedge clk) disable iff (!arst_n)
        ce && seq_done_q |=> irq_stat_q[IRQ_DONE_BIT]) else $error("completion not latched");
    a_restart_sets_irq: assert property (@(posedge clk) disable iff (!arst_n)
        ce && state_q == SEQ_WAIT && restart && !advance |=> irq_stat_q[IRQ_RESTART_BIT])
        else $error("restart not latched");
    a_trace_open: assert property (@(posedge clk) disable iff (!arst_n)
        trace_start_req && gate_q[level_q] |-> trace_start_ok) else $error("gated trace start refused");
    // bus answers must stand until taken
    a_rdata_holds: assert property (@(posedge clk) disable iff (!arst_n)
        s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata) && $stable(s_rresp))
        else $error("read answer moved before taken");
    a_bresp_holds: assert property (@(posedge clk) disable iff (!arst_n)
        s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp)) else $error("write answer moved before taken");
    a_write_refused: assert property (@(posedge clk) disable iff (!arst_n)
        s_bvalid |-> !s_awready && !s_wready) else $error("write taken under open response");
    a_read_refused: assert property (@(posedge clk) disable iff (!arst_n)
        s_rvalid |-> !s_arready) else $error("read taken under open response");
endmodule : event_sequencer

//--- verification/qual_src.sv
`timescale 1ns/1ps
// qualifier and trace sources; each fire bit is registered onto its line one cycle later
module qual_src (
    // clock
    input wire logic clk,
    input wire logic arst_n,
    // commands from the bench
    input wire logic [5:0] fire,
    input wire logic trace_in,
    // qualifier lines
    output logic event_a_match,
    output logic event_b_match,
    output logic event_c_match,
    output logic event_d_match,
    output logic counter_one_zero,
    output logic counter_two_zero,
    output logic trace_start_req
);
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {counter_two_zero, counter_one_zero, event_d_match, event_c_match, event_b_match, event_a_match} <= 6'h00;
            trace_start_req <= 1'b0;
        end else begin
            // registered, so pulses never straddle the design's sampling edge
            {counter_two_zero, counter_one_zero, event_d_match, event_c_match, event_b_match, event_a_match} <= fire;
            trace_start_req <= trace_in;
        end
    end
endmodule : qual_src

//--- verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import seq_pkg::*;;
    logic clk = 0, arst_n = 0, ce = 0, tr = 0;
    logic [5:0] fq = 6'h00;
    logic event_a_match, event_b_match, event_c_match, event_d_match;
    logic counter_one_zero, counter_two_zero, trace_start_req, trace_start_ok;
    logic [LVL_W-1:0] level_q;
    logic seq_done_q, trigger_q, irq;
    logic [ACT_W-1:0] action_q;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'h0;
    logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    logic [1:0] s_bresp, s_rresp;
    logic [33:0] rq[$];
    logic dq[$];
    int failures = 0, tests_run = 0, cyc = 0;

    always #12.5 clk = ~clk;

    qual_src u_src (.clk, .arst_n, .fire(fq), .trace_in(tr), .event_a_match, .event_b_match, .event_c_match,
        .event_d_match, .counter_one_zero, .counter_two_zero, .trace_start_req);
    event_sequencer uut (.clk, .arst_n, .ce, .event_a_match, .event_b_match, .event_c_match, .event_d_match,
        .counter_one_zero, .counter_two_zero, .trace_start_req, .level_q, .seq_done_q, .trace_start_ok,
        .action_q, .trigger_q, .irq, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid,
        .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp,
        .s_rvalid, .s_rready);

    task chk(input string n, input logic [33:0] e, input logic [33:0] g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task results();
        $display("tests_run %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    function logic [33:0] ok(input logic [31:0] d);
        return {AXI_OKAY, d};
    endfunction : ok

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        ta = 0;
        tw = 0;
        @(posedge clk);
        s_awaddr <= a;
        s_wdata <= d;
        s_wstrb <= 4'hF;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        // ready is combinational, so its mid-cycle value is what the next edge samples
        while (!(ta && tw)) begin
            @(negedge clk);
            ta = ta | s_awready;
            tw = tw | s_wready;
            @(posedge clk);
            if (ta) s_awvalid <= 1'b0;
            if (tw) s_wvalid <= 1'b0;
        end
        do @(negedge clk); while (s_bvalid !== 1'b1);
        chk("bresp", AXI_OKAY, s_bresp);
        @(posedge clk);
        s_bready <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        @(posedge clk);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do @(negedge clk); while (s_arready !== 1'b1);
        @(posedge clk);
        s_arvalid <= 1'b0;
        do @(negedge clk); while (s_rvalid !== 1'b1);
        @(posedge clk);
        s_rready <= 1'b0;
    endtask : rd

    task st(input logic [2:0] l);
        rd(OFF_STATUS, ok({29'h0, l}));
    endtask : st

    task fire(input logic [5:0] m);
        @(posedge clk);
        fq <= m;
        @(posedge clk);
        fq <= 6'h00;
        repeat (2) @(posedge clk);
    endtask : fire

    // results appear mid-cycle; oldest note is matched against each one
    always @(negedge clk) begin
        if (s_rvalid === 1'b1 && s_rready === 1'b1) begin
            if (rq.size() == 0) chk("read extra", 0, 1);
            else chk("rdata", rq.pop_front(), {s_rresp, s_rdata});
        end
        if (seq_done_q === 1'b1) begin
            if (dq.size() == 0) chk("done extra", 0, 1);
            else begin
                void'(dq.pop_front());
                chk("trigger", 1, trigger_q);
                chk("level after done", 0, level_q);
            end
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    initial begin
        logic [5:0] mk[8];
        int fs[8];
        int q, p;
        void'($urandom(94));
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        ce <= 1'b1;
        rd(OFF_GATE, ok(32'hFF));
        st(0);
        rd(OFF_IRQ_MASK, ok(32'h0));
        rd(8'hFC, {AXI_SLVERR, 32'h0});
        wr(OFF_ACTION, 32'h3FF);
        rd(OFF_ACTION, ok(32'h3FF));
        chk("action", 34'h3FF, {24'h0, action_q});
        wr(OFF_CELL0, 32'h001);
        wr(OFF_CELL0 + 8'h04, 32'h006);
        wr(OFF_CELL0 + 8'h08, 32'h100);
        rd(OFF_CELL0 + 8'h04, ok(32'h006));
        wr(OFF_DEPTH, 32'h2);
        fire(6'h02);
        st(0);
        fire(6'h01);
        st(1);
        wr(OFF_CTRL, 32'h1);
        st(0);
        fire(6'h01);
        fire(6'h01);
        st(0);
        chk("irq masked", 0, irq);
        wr(OFF_IRQ_MASK, 32'h1);
        fire(6'h01);
        fire(6'h03);
        st(2);
        fire(6'h01);
        st(2);
        dq.push_back(1'b1);
        fire(6'h10);
        st(0);
        chk("irq set", 1, irq);
        rd(OFF_IRQ_STAT, ok(32'h3));
        wr(OFF_IRQ_STAT, 32'h3);
        rd(OFF_IRQ_STAT, ok(32'h0));
        chk("irq cleared", 0, irq);
        wr(OFF_GATE, 32'hFE);
        @(posedge clk);
        tr <= 1'b1;
        repeat (2) @(negedge clk);
        chk("trace gated", 0, trace_start_ok);
        fire(6'h01);
        @(negedge clk);
        chk("trace open", 1, trace_start_ok);
        @(posedge clk);
        tr <= 1'b0;
        // random pair of advancing qualifiers per level, one of them fired
        for (int n = 0; n < 8; n++) begin
            q = $urandom % 6;
            p = (q + 1) % 6;
            mk[n] = 6'h01 << q | 6'h01 << p;
            fs[n] = ($urandom % 2) ? q : p;
            wr(OFF_CELL0 + 8'(4 * n), (32'h1 << 2 * q) | (32'h1 << 2 * p));
        end
        wr(OFF_DEPTH, 32'h7);
        wr(OFF_CTRL, 32'h1);
        for (int n = 0; n < 8; n++) begin
            fire(6'h3F & ~mk[n]);
            if (n == 7) dq.push_back(1'b1);
            fire(6'h01 << fs[n]);
            if (n == 3) st(4);
        end
        st(0);
        chk("done pending", 0, 34'(dq.size()));
        results();
    end
endmodule : tb_top
